//--- common/epw_pkg.sv
// Package of constants and carrier types for the page write host controller
package epw_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int PAGE_LSB = 6;
	localparam int PAGE_BYTES = 64;
	localparam int CLK_MHZ = 100;
	// Byte-load window, longest gap between loads, in us
	localparam int BLW_US = 150;
	localparam int BLW_CYC = (BLW_US * CLK_MHZ);
	// Host keeps well inside the window
	localparam int GAP_CYC = BLW_CYC / 2;
	// Write cycle time in us, standard and fast variants
	localparam int TWC_STD_US = 10000;
	localparam int TWC_FAST_US = 3000;
	localparam int TWC_STD_CYC = TWC_STD_US * CLK_MHZ;
	localparam int TWC_FAST_CYC = TWC_FAST_US * CLK_MHZ;
	// Strobe timing: pulse 100 ns min, high 50 ns min, read strobe and read gap 150 ns
	localparam int TWP_NS = 100;
	localparam int TWPH_NS = 50;
	localparam int TOEHP_NS = 150;
	localparam int CLK_NS = 10;
	localparam int TWP_CYC = (TWP_NS + CLK_NS - 1) / CLK_NS;
	localparam int TWPH_CYC = (TWPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRD_CYC = (TOEHP_NS + CLK_NS - 1) / CLK_NS;
	// Command sequences
	localparam logic [14:0] CMD_ADDR_A = 15'h5555;
	localparam logic [14:0] CMD_ADDR_B = 15'h2aaa;
	localparam logic [7:0] CMD_DATA_1 = 8'haa;
	localparam logic [7:0] CMD_DATA_2 = 8'h55;
	localparam logic [7:0] CMD_LOCK_ON = 8'ha0;
	localparam logic [7:0] CMD_LOCK_OFF = 8'h20;
	localparam logic [7:0] CMD_OFF_4 = 8'h80;
	localparam int TOGGLE_BIT = 6;

	typedef enum logic [1:0] {
		EPW_OP_PAGE,
		EPW_OP_LOCK_ON,
		EPW_OP_LOCK_OFF
	} epw_op_e;

	typedef struct packed {
		logic [14:0] addr;
		logic [7:0]  data;
	} epw_byte_s;

	typedef struct packed {
		logic        cs_n;
		logic        oe_n;
		logic        we_n;
		logic [14:0] addr;
		logic [7:0]  dout;
		logic        dout_en;
	} epw_pins_s;
endpackage

//--- verilog/epw_host.sv
// Host controller that drives page writes and write-lock sequences into the memory
//------------------------------------------------------------
// Rules of the memory device that this block works with
// RULE_01 - Every byte strobe in one page carries the same page number.
// RULE_02 - Output gate stays high while write strobe and select are low.
// RULE_03 - Next byte load starts within 150 us of the previous one.
// RULE_04 - Device writes loaded bytes once the load window lapses.
// RULE_05 - Lock on: AA to 5555, 55 to 2AAA, A0 to 5555.
// RULE_06 - One to sixty-four data bytes may follow the command bytes.
// RULE_07 - Lock takes effect at end of write even with no data.
// RULE_08 - Unlock takes effect at end of write even with no data.
// RULE_09 - Command data on data lines 7..0, addresses on lines 14..0.
// RULE_10 - During write, toggle status line inverts on each read.
// RULE_11 - Locked plain write starts timer only; reads poll status.
// RULE_12 - Lock starts off and persists until unlocked.
// RULE_13 - Internal write completes within 10 ms, or 3 ms fast.
// RULE_14 - No new load until end-of-write is detected.
//------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module epw_host
	import epw_pkg::*;
#(
	parameter int TWC_CYC = TWC_STD_CYC,
	parameter int WIN_CYC = GAP_CYC
)(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        start,
	input  wire epw_op_e     op,
	input  wire logic        fast,
	output logic             cmd_ready,
	input  wire epw_byte_s   wr_byte,
	input  wire logic        wr_last,
	input  wire logic        wr_valid,
	output logic             wr_ready,
	output logic             done,
	output logic             timeout,
	output epw_pins_s        pins,
	input  wire logic [7:0]  mem_din
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD,
		ST_WAIT,
		ST_STROBE,
		ST_HIGH,
		ST_POLL,
		ST_RDGAP
	} epw_st_e;

	typedef struct packed {
		epw_st_e     st;
		epw_op_e     op;
		logic [2:0]  step;
		logic        data_phase;
		logic        last;
		logic [8:0]  page;
		logic [6:0]  nbytes;
		logic [31:0] cnt;
		logic [31:0] wcnt;
		logic        have_prev;
		logic        prev_bit;
		logic        fast;
		epw_pins_s   pins;
		logic        done;
		logic        timeout;
	} epw_state_s;

	epw_state_s s_r;
	epw_state_s s_nxt;

	// Command byte for a sequence step
	function automatic epw_byte_s cmd_byte(input epw_op_e o, input logic [2:0] k);
		epw_byte_s b;
		b.addr = CMD_ADDR_A;
		b.data = CMD_DATA_1;
		case (k)
			3'h1, 3'h4:
			begin
				b.addr = CMD_ADDR_B;
				b.data = CMD_DATA_2;
			end
			3'h2: b.data = (o == EPW_OP_LOCK_ON) ? CMD_LOCK_ON : CMD_OFF_4;
			3'h5: b.data = CMD_LOCK_OFF;
			default: b.data = CMD_DATA_1;
		endcase
		return b;
	endfunction

	function automatic logic [2:0] cmd_len(input epw_op_e o);
		return (o == EPW_OP_LOCK_OFF) ? 3'h6 : 3'h3;
	endfunction

	logic [31:0] twc_lim;
	assign twc_lim = s_r.fast ? 32'(TWC_FAST_CYC) : 32'(TWC_CYC); // [RULE_13]

	epw_byte_s   cbyte;
	logic        win_open;
	assign cbyte = cmd_byte(s_r.op, s_r.step);
	// Strobe high time around the wait also counts toward the load gap [RULE_03]
	assign win_open = !s_r.last && (s_r.nbytes < 7'(PAGE_BYTES))
		&& ((s_r.op == EPW_OP_PAGE && s_r.nbytes == 7'h0)
		|| (s_r.cnt + 32'(TWPH_CYC + 3) < 32'(WIN_CYC)));

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.timeout = 1'b0;
		s_nxt.cnt = s_r.cnt + 32'h1;
		s_nxt.wcnt = s_r.wcnt + 32'h1;
		case (s_r.st)
			ST_IDLE:
			begin
				if (start)
				begin
					s_nxt.op = op;
					s_nxt.fast = fast;
					s_nxt.step = 3'h0;
					s_nxt.nbytes = 7'h0;
					s_nxt.last = 1'b0;
					// Plain page write skips commands
					s_nxt.data_phase = (op == EPW_OP_PAGE);
					s_nxt.st = (op == EPW_OP_PAGE) ? ST_WAIT : ST_CMD;
					s_nxt.cnt = 32'h0;
				end
			end
			ST_CMD:
			begin
				// Load one command byte at its fixed address [RULE_05] [RULE_09]
				s_nxt.pins.addr = cbyte.addr;
				s_nxt.pins.dout = cbyte.data;
				s_nxt.pins.dout_en = 1'b1;
				s_nxt.pins.oe_n = 1'b1; // [RULE_02]
				s_nxt.last = 1'b0;
				s_nxt.st = ST_STROBE;
				s_nxt.cnt = 32'h0;
			end
			ST_WAIT:
			begin
				// Page load closes if no byte arrives in time [RULE_03] [RULE_04]
				if (wr_valid && win_open)
				begin
					s_nxt.pins.addr = wr_byte.addr;
					if (s_r.nbytes != 7'h0)
						s_nxt.pins.addr[ADDR_W-1:PAGE_LSB] = s_r.page; // [RULE_01]
					else
						s_nxt.page = wr_byte.addr[ADDR_W-1:PAGE_LSB];
					s_nxt.pins.dout = wr_byte.data;
					s_nxt.pins.dout_en = 1'b1;
					s_nxt.pins.oe_n = 1'b1; // [RULE_02]
					s_nxt.last = wr_last || (s_r.nbytes == 7'(PAGE_BYTES - 1)); // [RULE_06]
					s_nxt.nbytes = s_r.nbytes + 7'h1;
					s_nxt.st = ST_STROBE;
					s_nxt.cnt = 32'h0;
				end
				else if (s_r.last && s_r.cnt >= 32'(2 * WIN_CYC))
				begin
					// Quiet for a whole device window, so its write has begun [RULE_07] [RULE_08]
					s_nxt.st = ST_POLL;
					s_nxt.have_prev = 1'b0;
					s_nxt.cnt = 32'h0;
				end
				else if (!s_r.last && !win_open && (s_r.nbytes != 7'h0 || s_r.op != EPW_OP_PAGE))
					s_nxt.last = 1'b1; // [RULE_03]
			end
			ST_STROBE:
			begin
				s_nxt.pins.cs_n = 1'b0;
				s_nxt.pins.we_n = 1'b0;
				if (s_r.cnt >= 32'(TWP_CYC))
				begin
					s_nxt.pins.cs_n = 1'b1;
					s_nxt.pins.we_n = 1'b1;
					s_nxt.st = ST_HIGH;
					s_nxt.cnt = 32'h0;
				end
			end
			ST_HIGH:
			begin
				// Hold address and data past the rising strobe
				if (s_r.cnt >= 32'(TWPH_CYC))
				begin
					s_nxt.pins.dout_en = 1'b0;
					s_nxt.cnt = 32'h0;
					s_nxt.wcnt = 32'h0;
					s_nxt.have_prev = 1'b0;
					if (!s_r.data_phase)
					begin
						s_nxt.step = s_r.step + 3'h1;
						if (s_r.step + 3'h1 == cmd_len(s_r.op))
						begin
							s_nxt.data_phase = 1'b1;
							s_nxt.st = ST_WAIT;
						end
						else
							s_nxt.st = ST_CMD;
					end
					else
						s_nxt.st = ST_WAIT;
				end
			end
			ST_POLL:
			begin
				// Read with output gate low, compare toggle line [RULE_10] [RULE_11]
				s_nxt.pins.cs_n = 1'b0;
				s_nxt.pins.oe_n = 1'b0;
				if (s_r.cnt >= 32'(TRD_CYC))
				begin
					s_nxt.pins.cs_n = 1'b1;
					s_nxt.pins.oe_n = 1'b1;
					s_nxt.have_prev = 1'b1;
					s_nxt.prev_bit = mem_din[TOGGLE_BIT];
					s_nxt.st = ST_RDGAP;
					s_nxt.cnt = 32'h0;
					if (s_r.have_prev && s_r.prev_bit == mem_din[TOGGLE_BIT])
					begin
						s_nxt.st = ST_IDLE;
						s_nxt.done = 1'b1;
					end
				end
			end
			ST_RDGAP:
			begin
				if (s_r.wcnt >= twc_lim)
				begin
					// Longest write time elapsed [RULE_13] [RULE_14]
					s_nxt.st = ST_IDLE;
					s_nxt.done = 1'b1;
					s_nxt.timeout = 1'b1;
				end
				else if (s_r.cnt >= 32'(TRD_CYC))
				begin
					s_nxt.st = ST_POLL;
					s_nxt.cnt = 32'h0;
				end
			end
			default: s_nxt.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
			s_r.pins.cs_n <= 1'b1;
			s_r.pins.oe_n <= 1'b1;
			s_r.pins.we_n <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// New work only after end-of-write [RULE_14]
	assign cmd_ready = (s_r.st == ST_IDLE);
	assign wr_ready = (s_r.st == ST_WAIT) && s_r.data_phase && win_open;
	assign done = s_r.done;
	assign timeout = s_r.timeout;
	assign pins = s_r.pins;
endmodule
`default_nettype wire

//--- verif/epw_host_properties.sv
// Checker on the host controller pins
`timescale 1ns/100ps
`default_nettype none
module epw_host_properties
	import epw_pkg::*;
#(parameter int TWC_CYC = TWC_STD_CYC, parameter int WIN_CYC = GAP_CYC)(
	input wire logic      clk,
	input wire logic      rstn,
	input wire epw_op_e   op,
	input wire logic      cmd_ready,
	input wire logic      done,
	input wire logic      timeout,
	input wire epw_pins_s pins
);
	logic [6:0]  n_r;
	logic [15:0] gap_r;
	logic [8:0]  pg_r;
	wire         fl = !pins.we_n && gap_r != 16'h0;
	//----
	// Strobe count, gap and page
	//----
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			n_r <= '0;
			gap_r <= '0;
			pg_r <= '0;
		end
		else
		begin
			gap_r <= pins.we_n ? gap_r + 16'h1 : 16'h0;
			n_r <= cmd_ready ? 7'h0 : n_r + {6'h0, fl};
			if (fl && n_r == 7'h0)
				pg_r <= pins.addr[14:6];
		end
	function automatic logic [22:0] on_seq(input logic [6:0] i);
		return i == 7'h0 ? {CMD_ADDR_A, CMD_DATA_1} : i == 7'h1 ? {CMD_ADDR_B, CMD_DATA_2}
			: {CMD_ADDR_A, CMD_LOCK_ON};
	endfunction
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_oe_gate: assert property (!pins.we_n && !pins.cs_n |-> pins.oe_n)
		else $error("oe low in write");
	a_page_same: assert property (fl && n_r != 0 && op == EPW_OP_PAGE |-> pins.addr[14:6] == pg_r)
		else $error("page moved");
	a_load_gap: assert property (fl && n_r != 0 |-> gap_r < WIN_CYC)
		else $error("load gap long");
	a_lock_cmd: assert property (fl && op == EPW_OP_LOCK_ON && n_r < 3 |->
		{pins.addr, pins.dout} == on_seq(n_r)) else $error("lock command");
	a_data_drive: assert property (!pins.we_n |-> pins.dout_en)
		else $error("data not driven");
	a_read_quiet: assert property (!pins.oe_n |-> pins.we_n && !pins.dout_en)
		else $error("read clash");
	a_timeout_done: assert property (timeout |-> done)
		else $error("timeout alone");
	a_done_idle: assert property (done |-> pins.cs_n && pins.we_n)
		else $error("access at done");
	c_timeout: cover property (timeout);
	c_unlock: cover property (fl && op == EPW_OP_LOCK_OFF);
	c_full_page: cover property (fl && n_r == 7'd63);
endmodule
bind epw_host epw_host_properties #(.TWC_CYC(TWC_CYC), .WIN_CYC(WIN_CYC)) u_prop (.clk, .rstn,
	.op, .cmd_ready, .done, .timeout, .pins);
`default_nettype wire

//--- verif/epw_mem_model.sv
// Behavioural memory answering the host controller pins
`timescale 1ns/100ps
`default_nettype none
module epw_mem_model
	import epw_pkg::*;
#(parameter int MW = 80)(
	input  wire logic        clk,
	input  wire epw_pins_s   pins,
	input  wire logic [15:0] wt,
	output logic [7:0]       mem_din
);
	logic [7:0]  mem [0:32767];
	logic [22:0] q [$];
	logic        lock = 1'b0;
	logic        nl = 1'b0;
	logic        busy = 1'b0;
	logic        tog = 1'b0;
	logic        we_p = 1'b1;
	logic        oe_p = 1'b1;
	int          gap = 0;
	int          bt = 0;
	int          cy = 0;
	int          k;
	initial
		for (k = 0; k < 32768; k++)
			mem[k] = 8'h00;
	//----
	// Byte load, window, timer
	//----
	always @(posedge clk)
	begin
		cy <= cy + 1;
		we_p <= pins.we_n;
		oe_p <= pins.oe_n;
		if (!pins.we_n && we_p && !pins.cs_n)
		begin
			q.push_back({pins.addr, pins.dout});
			gap <= 0;
		end
		else if (q.size() != 0 && !busy)
			gap <= gap + 1;
		if (gap == MW)
		begin
			k = 0;
			if (q.size() > 2 && q[0] == {CMD_ADDR_A, CMD_DATA_1} && q[1] == {CMD_ADDR_B, CMD_DATA_2})
				k = q[2] == {CMD_ADDR_A, CMD_LOCK_ON} ? 3 : 6;
			if (k == 6 && !(q.size() > 5 && q[5] == {CMD_ADDR_A, CMD_LOCK_OFF}))
				k = 0;
			nl = k == 3 ? 1'b1 : k == 6 ? 1'b0 : lock;
			if (k != 0 || !lock)
				for (; k < q.size(); k++)
					mem[q[k][22:8]] = q[k][7:0];
			q.delete();
			gap <= 0;
			busy <= 1'b1;
			bt <= wt;
		end
		if (busy)
		begin
			bt <= bt - 1;
			if (bt == 1)
			begin
				busy <= 1'b0;
				lock <= nl;
			end
		end
		if (!pins.oe_n && oe_p && !pins.cs_n && busy)
			tog <= !tog;
	end
	assign mem_din = (pins.cs_n || pins.oe_n) ? cy[7:0] : busy ? {1'b0, tog, 6'h0} : mem[pins.addr];
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the page write host controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import epw_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        start = 1'b0;
	epw_op_e     op = EPW_OP_PAGE;
	logic        fast = 1'b0;
	epw_byte_s   wr_byte = '0;
	logic        wr_last = 1'b0;
	logic        wr_valid = 1'b0;
	logic [15:0] wt = 16'd60;
	logic        cmd_ready, wr_ready, done, timeout, lk;
	epw_pins_s   pins;
	logic [7:0]  mem_din;
	logic [7:0]  exp_mem [0:32767];
	int          fail_count = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          i;
	epw_host #(.TWC_CYC(200), .WIN_CYC(50)) dut (.clk, .rstn, .start, .op, .fast, .cmd_ready,
		.wr_byte, .wr_last, .wr_valid, .wr_ready, .done, .timeout, .pins, .mem_din);
	epw_mem_model #(.MW(80)) m (.clk, .pins, .wt, .mem_din);
	initial
		forever #5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			fail_count++;
			final_report();
		end
	end
	task automatic check(input logic c, input string s);
		num_checks++;
		if (c !== 1'b1)
		begin
			fail_count++;
			$display("FAIL %0t %s", $time, s);
		end
	endtask
	task automatic final_report();
		if (fail_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	//----
	// One operation with its checks
	//----
	task automatic scen(input epw_op_e o, input int n, input logic to_x);
		logic [8:0]  pg;
		logic [14:0] a;
		int          j;
		pg = 9'($urandom);
		op = o;
		fast = to_x ? 1'b0 : 1'($urandom);
		start = 1'b1;
		@(posedge clk) #1;
		start = 1'b0;
		for (j = 0; j < n; j++)
		begin
			a = {pg, 6'($urandom)};
			wr_byte = {a, 8'($urandom)};
			wr_last = j == n - 1;
			wr_valid = 1'b1;
			while (wr_ready !== 1'b1)
				@(posedge clk) #1;
			@(posedge clk) #1;
			if (o != EPW_OP_PAGE || !lk)
				exp_mem[a] = wr_byte.data;
		end
		wr_valid = 1'b0;
		while (done !== 1'b1)
			@(posedge clk) #1;
		if (o != EPW_OP_PAGE)
			lk = o == EPW_OP_LOCK_ON;
		check(timeout === to_x, "timeout flag");
		if (!to_x)
			check(m.lock === lk, "lock state");
		for (j = 0; j < 64; j++)
			check(m.mem[{pg, 6'(j)}] === exp_mem[{pg, 6'(j)}], "memory");
		repeat (to_x ? 500 : 2) @(posedge clk) #1;
	endtask
	initial
	begin
		lk = 1'b0;
		for (i = 0; i < 32768; i++)
			exp_mem[i] = 8'h00;
		void'($urandom(32'hd2f5));
		repeat (12) @(posedge clk);
		#1 rstn = 1'b1;
		check(pins.cs_n & pins.we_n & pins.oe_n & !pins.dout_en & cmd_ready, "reset");
		scen(EPW_OP_PAGE, 64, 1'b0);
		scen(EPW_OP_LOCK_ON, 0, 1'b0);
		scen(EPW_OP_PAGE, 5, 1'b0);
		scen(EPW_OP_LOCK_ON, 7, 1'b0);
		scen(EPW_OP_LOCK_OFF, 0, 1'b0);
		repeat (4) scen(EPW_OP_PAGE, 1 + $urandom % 64, 1'b0);
		wt = 16'd400;
		scen(EPW_OP_PAGE, 3, 1'b1);
		final_report();
	end
endmodule
`default_nettype wire
